/* inc/gls_cfg.svh */
`ifndef GLS_CFG_SVH
`define GLS_CFG_SVH

// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define GLS_OFF_CTRL      8'h00
`define GLS_OFF_UNL_TIME  8'h04
`define GLS_OFF_FBK_TIME  8'h08
`define GLS_OFF_STATUS    8'h0C
`define GLS_OFF_INT_STAT  8'h10
`define GLS_OFF_INT_MASK  8'h14

// ------------------------------------------------------------
// Control fields and reset values
// ------------------------------------------------------------
`define GLS_CTRL_GATE_ABSENT 0
`define GLS_CTRL_MANDATORY   1
`define GLS_CTRL_SPRING      2
`define GLS_CTRL_ERR_EN      3
`define GLS_CTRL_W           4
`define GLS_CTRL_RST         4'h0

// ------------------------------------------------------------
// Interrupt status fields
// ------------------------------------------------------------
`define GLS_INT_ERROR     0
`define GLS_INT_CYCLE     1
`define GLS_INT_TIMEOUT   2
`define GLS_INT_W         3

// ------------------------------------------------------------
// Timing: clock rate and default times
// ------------------------------------------------------------
`define GLS_CLK_KHZ       200000
`define GLS_UNLOCK_MS     500
`define GLS_FBK_MS        100
`define GLS_UNLOCK_CYC    (`GLS_UNLOCK_MS * `GLS_CLK_KHZ)
`define GLS_FBK_CYC       (`GLS_FBK_MS * `GLS_CLK_KHZ)

`endif

/* inc/gls_pkg.sv */
package gls_pkg;
    // ------------------------------------------------------------
    // Lock cycle states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        gls_st_idle   = 3'h0,
        gls_st_delay  = 3'h1,
        gls_st_rel_fb = 3'h2,
        gls_st_open   = 3'h3,
        gls_st_eng_fb = 3'h4
    } gls_state_t;
endpackage

/* hdl/gls_guard_lock.sv */
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "gls_cfg.svh"
// How it works
// - Main output high only while door closed or declared absent and lock confirmed engaged.
// - Unlock request high means release; low means keep locked.
// - Unlock request drops the main output one clock later and starts release.
// - Lock drive changes to release only after the unlock delay.
// - Lock feedback must follow each drive change within feedback time.
// - Door open while engaged is an error and forces main output low.
// - With a door, re-engage only once request gone and door closed.
// - With a door, main output returns only when engaged and closed.
// - Mandatory opening needs door present and mandatory setting set.
// - Mandatory opening: no door opening after unlock is an error.
// - That error raises the error output at the end of the cycle.
// - Spring option: drive high releases the lock, low engages it.
// - Error output, when enabled, is high while an error is latched.
// - Without a door, main output follows confirmed engagement only.
module gls_guard_lock #(
    parameter int CNT_W = 32,
    parameter logic [31:0] UNL_TIME_RST = `GLS_UNLOCK_CYC,
    parameter logic [31:0] FBK_TIME_RST = `GLS_FBK_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic unlock_req,
    input wire logic lock_fbk,
    input wire logic door_closed,
    output logic lock_drive,
    output logic main_out,
    output logic error_flag,
    output logic irq
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (CNT_W < 8 || CNT_W > 32) begin : g_bad_width
        $error("CNT_W must lie between 8 and 32");
    end

    // Drive level for a release request under the chosen lock type
    function automatic logic gls_lock_level(input logic spring,
                                            input logic rel);
        gls_lock_level = spring ? rel : !rel;
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    gls_pkg::gls_state_t state_reg;
    gls_pkg::gls_state_t state_next;
    logic [`GLS_CTRL_W-1:0] ctrl_reg;
    logic [CNT_W-1:0] unl_time_reg;
    logic [CNT_W-1:0] fbk_time_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [`GLS_INT_W-1:0] int_stat_reg;
    logic [`GLS_INT_W-1:0] int_mask_reg;
    logic err_reg;
    logic cyc_fault_reg;
    logic door_seen_reg;
    logic gate_absent, mand_mode, spring, err_en, door_ok;
    logic timeout, door_fault, mand_miss, cycle_end, cycle_start;
    logic err_set, wr_en, rd_setup;
    logic [31:0] rd_mux;
    logic addr_ok;

    assign gate_absent = ctrl_reg[`GLS_CTRL_GATE_ABSENT];
    assign mand_mode = !gate_absent && ctrl_reg[`GLS_CTRL_MANDATORY];
    assign spring = ctrl_reg[`GLS_CTRL_SPRING];
    assign err_en = ctrl_reg[`GLS_CTRL_ERR_EN];
    // No door input counts when the door is declared absent
    assign door_ok = gate_absent || door_closed;

    // ------------------------------------------------------------
    // Lock cycle sequencer
    // ------------------------------------------------------------
    // Next state and cycle events
    always_comb begin
        state_next = state_reg;
        timeout = 1'b0;
        door_fault = 1'b0;
        case (state_reg)
            gls_pkg::gls_st_idle: begin
                if (unlock_req) begin
                    state_next = gls_pkg::gls_st_delay;
                end
                door_fault = lock_fbk && !door_ok;
            end
            gls_pkg::gls_st_delay: begin
                // Request withdrawn early: lock never moved
                if (!unlock_req) begin
                    state_next = gls_pkg::gls_st_idle;
                end else if (cnt_reg >= unl_time_reg) begin
                    state_next = gls_pkg::gls_st_rel_fb;
                end
                door_fault = lock_fbk && !door_ok;
            end
            gls_pkg::gls_st_rel_fb: begin
                if (!lock_fbk) begin
                    state_next = gls_pkg::gls_st_open;
                end else if (cnt_reg >= fbk_time_reg) begin
                    timeout = 1'b1;
                    state_next = gls_pkg::gls_st_open;
                end
            end
            gls_pkg::gls_st_open: begin
                if (!unlock_req && door_ok) begin
                    state_next = gls_pkg::gls_st_eng_fb;
                end
            end
            gls_pkg::gls_st_eng_fb: begin
                if (lock_fbk) begin
                    state_next = gls_pkg::gls_st_idle;
                end else if (cnt_reg >= fbk_time_reg) begin
                    timeout = 1'b1;
                    state_next = gls_pkg::gls_st_idle;
                end
            end
            default: begin
                state_next = gls_pkg::gls_st_idle;
            end
        endcase
    end

    assign cycle_start = (state_reg == gls_pkg::gls_st_idle) && unlock_req;
    assign cycle_end = (state_reg == gls_pkg::gls_st_eng_fb) &&
                       (state_next == gls_pkg::gls_st_idle);
    // Door opening must have been seen by the time the lock closes again
    assign mand_miss = cycle_end && mand_mode && !door_seen_reg;
    assign err_set = timeout || door_fault || mand_miss;

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= gls_pkg::gls_st_idle;
        end else begin
            state_reg <= state_next;
        end
    end

    // Elapsed cycles in the current state, saturating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= '0;
        end else if (state_next != state_reg) begin
            cnt_reg <= '0;
        end else if (cnt_reg != {CNT_W{1'b1}}) begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    // Per-cycle bookkeeping for the clean-cycle and opening checks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_fault_reg <= 1'b0;
            door_seen_reg <= 1'b0;
        end else if (cycle_start) begin
            cyc_fault_reg <= door_fault;
            door_seen_reg <= 1'b0;
        end else begin
            cyc_fault_reg <= cyc_fault_reg || timeout || door_fault;
            door_seen_reg <= door_seen_reg || !door_closed;
        end
    end

    // Latched error: a fresh fault wins over the clean-cycle clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_reg <= 1'b0;
        end else if (err_set) begin
            err_reg <= 1'b1;
        end else if (cycle_end && !cyc_fault_reg) begin
            err_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Outputs to the lock and the safety logic
    // ------------------------------------------------------------
    // Released in every state past the unlock delay except re-engaging
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_drive <= 1'b1;
        end else begin
            lock_drive <= gls_lock_level(spring,
                (state_next == gls_pkg::gls_st_rel_fb) ||
                (state_next == gls_pkg::gls_st_open));
        end
    end

    // Main output falls one clock after a request or fault is seen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_out <= 1'b0;
        end else begin
            main_out <= (state_reg == gls_pkg::gls_st_idle) && !unlock_req &&
                        lock_fbk && door_ok && !err_reg &&
                        !err_set;
        end
    end

    // Error output only when enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            error_flag <= 1'b0;
        end else begin
            error_flag <= err_en && err_reg;
        end
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    assign wr_en = psel && penable && pready && pwrite && addr_ok;
    assign rd_setup = psel && !penable;

    // Address decode and read mux
    always_comb begin
        addr_ok = 1'b1;
        rd_mux = 32'h0;
        case (paddr)
            `GLS_OFF_CTRL: rd_mux[`GLS_CTRL_W-1:0] = ctrl_reg;
            `GLS_OFF_UNL_TIME: rd_mux[CNT_W-1:0] = unl_time_reg;
            `GLS_OFF_FBK_TIME: rd_mux[CNT_W-1:0] = fbk_time_reg;
            `GLS_OFF_STATUS: rd_mux[7:0] = {state_reg, err_reg, main_out,
                                            lock_drive, door_closed,
                                            lock_fbk};
            `GLS_OFF_INT_STAT: rd_mux[`GLS_INT_W-1:0] = int_stat_reg;
            `GLS_OFF_INT_MASK: rd_mux[`GLS_INT_W-1:0] = int_mask_reg;
            default: addr_ok = 1'b0;
        endcase
    end

    // Answer in the first access cycle; data captured at setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= rd_setup;
            pslverr <= rd_setup && !addr_ok;
            if (rd_setup && !pwrite) begin
                prdata <= rd_mux;
            end
        end
    end

    // Configuration registers; changing them mid-cycle takes effect at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `GLS_CTRL_RST;
            unl_time_reg <= UNL_TIME_RST[CNT_W-1:0];
            fbk_time_reg <= FBK_TIME_RST[CNT_W-1:0];
            int_mask_reg <= '0;
        end else if (wr_en) begin
            case (paddr)
                `GLS_OFF_CTRL: ctrl_reg <= pwdata[`GLS_CTRL_W-1:0];
                `GLS_OFF_UNL_TIME: unl_time_reg <= pwdata[CNT_W-1:0];
                `GLS_OFF_FBK_TIME: fbk_time_reg <= pwdata[CNT_W-1:0];
                `GLS_OFF_INT_MASK: int_mask_reg <= pwdata[`GLS_INT_W-1:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    // Sticky events, write one to clear; a same-cycle event survives
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_reg <= '0;
        end else begin
            int_stat_reg <= (int_stat_reg &
                ~((wr_en && paddr == `GLS_OFF_INT_STAT) ?
                  pwdata[`GLS_INT_W-1:0] : {`GLS_INT_W{1'b0}})) |
                {timeout, cycle_end, err_set};
        end
    end

    // Level interrupt from unmasked sticky bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_stat_reg & int_mask_reg);
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_main_engaged: assert property (
        main_out |-> $past(lock_fbk) && !$past(err_reg))
        else $error("main output high without confirmed lock");

    chk_main_door: assert property (
        main_out |-> $past(door_closed) || $past(gate_absent))
        else $error("main output high with door open");

    chk_unlock_drop: assert property (
        unlock_req |=> !main_out)
        else $error("main output not dropped on unlock request");

    chk_delay_wait: assert property (
        (state_reg == gls_pkg::gls_st_rel_fb &&
         $past(state_reg) == gls_pkg::gls_st_delay)
        |-> $past(cnt_reg) >= $past(unl_time_reg))
        else $error("lock released before unlock delay");

    chk_fbk_timeout: assert property (
        (state_reg == gls_pkg::gls_st_rel_fb && lock_fbk &&
         cnt_reg >= fbk_time_reg) |=> err_reg ##1 !main_out)
        else $error("feedback timeout not flagged");

    chk_door_fault: assert property (
        (state_reg == gls_pkg::gls_st_idle && lock_fbk && !door_closed &&
         !gate_absent) |=> err_reg && !main_out)
        else $error("door open while locked not flagged");

    chk_relock_door: assert property (
        (state_reg == gls_pkg::gls_st_open && !door_ok)
        |=> state_reg != gls_pkg::gls_st_eng_fb)
        else $error("lock re-engaged with door open");

    chk_mand_miss: assert property (
        (cycle_end && mand_mode && !door_seen_reg)
        |=> ##1 error_flag == err_en)
        else $error("missing door opening not reported");

    chk_drive_idle: assert property (
        (state_reg == gls_pkg::gls_st_idle)[*2] |->
        lock_drive == !$past(spring))
        else $error("lock drive not engaging in idle");

    chk_err_clear: assert property (
        $fell(err_reg) |-> $past(state_reg) == gls_pkg::gls_st_eng_fb)
        else $error("error cleared outside cycle end");

    chk_err_out: assert property (
        error_flag |-> $past(err_reg) && $past(err_en))
        else $error("error output without latched error");

    cov_clean_cycle: cover property (
        cycle_start ##[1:1000] cycle_end && !cyc_fault_reg);
    cov_timeout: cover property (timeout);
    cov_mand_miss: cover property (mand_miss);
    cov_door_cycle: cover property (
        state_reg == gls_pkg::gls_st_open && !door_closed);

endmodule

/* test/gls_lock_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Electromagnet with contact feedback
// ------------------------------------------------------------
module gls_lock_model (
    input wire logic pclk,
    input wire logic lock_drive,
    input wire logic spring,
    input wire logic [7:0] act_dly,
    output logic lock_fbk
);
    logic cmd_eng;
    logic last_eng = 1'b1;
    logic [7:0] age = 8'hFF;

    // A sprung lock stays engaged while the coil is dead
    assign cmd_eng = spring ? !lock_drive : lock_drive;

    // Contacts follow the coil only after the actuation time; the
    // bench stretches it past the feedback time to force a fault
    initial lock_fbk = 1'b1;
    always @(posedge pclk) begin
        if (cmd_eng !== last_eng) begin
            last_eng <= cmd_eng;
            age <= 8'h00;
        end else if (age < act_dly) begin
            age <= age + 8'h01;
        end else begin
            lock_fbk <= last_eng;
        end
    end
endmodule

/* test/guard_lock_supervisor_tb_top.sv */
`timescale 1ns/1ps
`include "gls_cfg.svh"
module guard_lock_supervisor_tb_top;
    // ------------------------------------------------------------
    // Settings and signals
    // ------------------------------------------------------------
    localparam int UNL = 4;
    localparam int FBK = 8;
    localparam logic [31:0] GA = 32'h1 << `GLS_CTRL_GATE_ABSENT;
    localparam logic [31:0] MD = 32'h1 << `GLS_CTRL_MANDATORY;
    localparam logic [31:0] SP = 32'h1 << `GLS_CTRL_SPRING;
    localparam logic [31:0] EE = 32'h1 << `GLS_CTRL_ERR_EN;
    localparam logic [31:0] IE = 32'h1 << `GLS_INT_ERROR;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic unlock_req = 1'b0;
    logic lock_fbk;
    logic door_closed = 1'b1;
    logic lock_drive;
    logic main_out;
    logic error_flag;
    logic irq;
    logic spring = 1'b0;
    logic [7:0] act_dly = 8'h03;
    int n_mismatch = 0;
    int checks_done = 0;
    int cyc = 0;
    logic [31:0] rd;
    logic er;

    always #2.5 pclk = ~pclk;

    gls_guard_lock #(.CNT_W(32), .UNL_TIME_RST(32'(UNL)),
        .FBK_TIME_RST(32'(FBK))) uut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .unlock_req(unlock_req), .lock_fbk(lock_fbk),
        .door_closed(door_closed), .lock_drive(lock_drive),
        .main_out(main_out), .error_flag(error_flag), .irq(irq));

    gls_lock_model magnet (.pclk(pclk), .lock_drive(lock_drive),
        .spring(spring), .act_dly(act_dly), .lock_fbk(lock_fbk));

    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    task automatic test_done;
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %0h seen %0h", nm, e, g);
        end
    endtask

    // One APB transfer; the request holds until pready is seen
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // No bound of its own: pready, or else the bench's hang guard, ends this wait
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        chk("pready wait", 1, n);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic drv(logic u, logic d);
        @(posedge pclk);
        unlock_req <= u;
        door_closed <= d;
    endtask

    // Bounded wait on an output, sampled mid-cycle
    task automatic wait_lvl(string nm, int sel, logic v, output int n);
        logic s;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
            case (sel)
                0: s = lock_drive;
                1: s = main_out;
                2: s = error_flag;
                default: s = lock_fbk;
            endcase
        end while (s !== v && n < 60);
        chk(nm, v, s);
    endtask

    // Full unlock/lock cycle, door optionally opened and closed
    task automatic lock_cycle(logic op, logic dd);
        int n;
        drv(1'b1, dd);
        wait_lvl("lock_drive", 0, 1'b1, n);
        wait_lvl("lock_fbk", 3, 1'b0, n);
        if (op) begin
            drv(1'b1, 1'b0);
            drv(1'b1, 1'b1);
        end
        drv(1'b0, dd);
        wait_lvl("lock_drive", 0, 1'b0, n);
        wait_lvl("lock_fbk", 3, 1'b1, n);
        repeat (4) @(negedge pclk);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        apb(1'b0, `GLS_OFF_CTRL, 32'h0);
        chk("ctrl", 32'h0, rd);
        apb(1'b0, `GLS_OFF_UNL_TIME, 32'h0);
        chk("unl_time", UNL, rd);
        apb(1'b0, `GLS_OFF_FBK_TIME, 32'h0);
        chk("fbk_time", FBK, rd);
        apb(1'b0, 8'h40, 32'h0);
        chk("pslverr", 1, er);
        chk("unmapped", 32'h0, rd);
    endtask

    task automatic t_door_mode;
        int n;
        apb(1'b1, `GLS_OFF_CTRL, SP);
        spring <= 1'b1;
        repeat (3) @(negedge pclk);
        chk("lock_drive", 0, lock_drive);
        chk("main_out", 1, main_out);
        drv(1'b1, 1'b1);
        repeat (2) @(negedge pclk);
        chk("main_out", 0, main_out);
        wait_lvl("lock_drive", 0, 1'b1, n);
        chk("unlock delay", 1, n + 2 >= UNL + 1 && n + 2 <= UNL + 3);
        wait_lvl("lock_fbk", 3, 1'b0, n);
        drv(1'b1, 1'b0);
        drv(1'b0, 1'b0);
        repeat (6) @(negedge pclk);
        chk("lock_drive", 1, lock_drive);
        chk("main_out", 0, main_out);
        drv(1'b0, 1'b1);
        wait_lvl("lock_drive", 0, 1'b0, n);
        chk("main_out", 0, main_out);
        wait_lvl("lock_fbk", 3, 1'b1, n);
        wait_lvl("main_out", 1, 1'b1, n);
        chk("main_out lag", 1, n <= 3);
    endtask

    task automatic t_nogate;
        apb(1'b1, `GLS_OFF_CTRL, SP | GA | EE);
        lock_cycle(1'b0, 1'b0);
        chk("main_out", 1, main_out);
        chk("error_flag", 0, error_flag);
    endtask

    task automatic t_timeout;
        int n;
        apb(1'b1, `GLS_OFF_INT_MASK, IE);
        act_dly = 8'h14;
        drv(1'b1, 1'b0);
        wait_lvl("lock_drive", 0, 1'b1, n);
        wait_lvl("error_flag", 2, 1'b1, n);
        chk("main_out", 0, main_out);
        chk("irq", 1, irq);
        act_dly = 8'h03;
        drv(1'b0, 1'b0);
        wait_lvl("lock_fbk", 3, 1'b1, n);
        repeat (4) @(negedge pclk);
        chk("error_flag", 1, error_flag);
        chk("main_out", 0, main_out);
        apb(1'b1, `GLS_OFF_INT_STAT, IE);
        repeat (2) @(negedge pclk);
        chk("irq", 0, irq);
        lock_cycle(1'b0, 1'b0);
        chk("error_flag", 0, error_flag);
        chk("main_out", 1, main_out);
    endtask

    task automatic t_door_fault;
        int n;
        // Close the door before the door input starts to count
        drv(1'b0, 1'b1);
        apb(1'b1, `GLS_OFF_CTRL, SP | EE);
        repeat (3) @(negedge pclk);
        chk("main_out", 1, main_out);
        drv(1'b0, 1'b0);
        repeat (2) @(negedge pclk);
        chk("main_out", 0, main_out);
        wait_lvl("error_flag", 2, 1'b1, n);
        drv(1'b0, 1'b1);
        repeat (4) @(negedge pclk);
        chk("main_out", 0, main_out);
        lock_cycle(1'b1, 1'b1);
        chk("error_flag", 0, error_flag);
        chk("main_out", 1, main_out);
    endtask

    task automatic t_mandatory;
        int n;
        apb(1'b1, `GLS_OFF_CTRL, SP | MD | EE);
        chk("error_flag", 0, error_flag);
        lock_cycle(1'b0, 1'b1);
        wait_lvl("error_flag", 2, 1'b1, n);
        chk("main_out", 0, main_out);
        lock_cycle(1'b1, 1'b1);
        chk("error_flag", 0, error_flag);
        apb(1'b1, `GLS_OFF_CTRL, SP | MD | GA | EE);
        lock_cycle(1'b0, 1'b1);
        chk("error_flag", 0, error_flag);
        chk("main_out", 1, main_out);
    endtask

    // ------------------------------------------------------------
    // Main sequence and hang guard
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_door_mode;
        t_nogate;
        t_timeout;
        t_door_fault;
        t_mandatory;
        test_done;
    end

    // Far beyond the few hundred cycles the scenarios need
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            test_done;
        end
    end
endmodule
